// file: hw/tpw_defs.svh
/*
 tpw_defs.svh: register offsets, field positions and reset values
 of the three-phase pwm timing unit.
 assumes: included by bare name wherever these numbers are needed.
*/
`ifndef TPW_DEFS_SVH
`define TPW_DEFS_SVH

// register byte offsets on the plain register port
`define TPW_ADDR_W 5
`define TPW_A_CTRL 5'h00
`define TPW_A_STAT 5'h04
`define TPW_A_PER 5'h08
`define TPW_A_DT 5'h0c
`define TPW_A_DUTY_A 5'h10
`define TPW_A_DUTY_B 5'h14
`define TPW_A_DUTY_C 5'h18
`define TPW_A_MASK 5'h1c

// field positions
`define TPW_CTRL_MODE_BIT 2
`define TPW_STAT_HALF_BIT 0
`define TPW_MASK_W 6

// reset values
`define TPW_RST_WORD 16'h0000
`define TPW_RST_DT 10'h000
`define TPW_RST_MASK 6'h00

`endif

// file: hw/tpw_pkg.sv
/*
 tpw_pkg: types shared by the pwm timing unit files.
 assumes: compiled before any module that imports it.
*/
package tpw_pkg;

    // half-cycle sequencer, one-hot
    typedef enum logic [2:0] {
        TPW_IDLE   = 3'b001,
        TPW_FIRST  = 3'b010,
        TPW_SECOND = 3'b100
    } tpw_state_t;

endpackage

// file: hw/tpw_phase_cmp.sv
/*
 tpw_phase_cmp: threshold compare of one output pair.
 assumes: counter runs up in the first half, down in the second;
 duty is two's complement, all inputs come from the same clock.
*/
`timescale 1ns/1ps

module tpw_phase_cmp
    import tpw_pkg::*;
#(
    parameter int CNT_W = 16,  // counter and duty width
    parameter int DT_W  = 10   // dead-time width
) (
    input  wire logic [CNT_W-1:0] cnt,   // center counter
    input  wire logic [CNT_W-1:0] per,   // latched half period
    input  wire logic [CNT_W-1:0] duty,  // latched duty, signed
    input  wire logic [DT_W-1:0]  dt,    // latched dead time
    output logic                  hi_on, // high side commanded on
    output logic                  lo_on  // low side commanded on
);

    // headroom so thresholds never wrap
    localparam int TW = CNT_W + 3;

    logic signed [TW-1:0] half_s;  // half of the half period
    logic signed [TW-1:0] duty_s;  // sign-extended duty
    logic signed [TW-1:0] dt_s;    // zero-extended dead time
    logic signed [TW-1:0] cnt_s;   // counter as signed
    logic signed [TW-1:0] thr_hi;  // high side turns on at or above
    logic signed [TW-1:0] thr_lo;  // low side on below

    assign half_s = $signed(TW'(per >> 1));
    assign duty_s = TW'(signed'(duty));
    assign dt_s   = $signed(TW'(dt));
    assign cnt_s  = $signed(TW'(cnt));

    // both edges move away from the duty instant by dt
    assign thr_hi = half_s - duty_s + dt_s;
    assign thr_lo = half_s - duty_s - dt_s;

    // a threshold past either end pins the output: 0% or 100%
    assign hi_on = cnt_s >= thr_hi;
    assign lo_on = cnt_s < thr_lo;

endmodule

// file: hw/tpw_timing_unit.sv
/*
 tpw_timing_unit: three-phase center-based pwm timing unit with
 dead time, single and double update, sync pulse and half status.
 assumes: one clock, synchronous active-low reset, a register master
 that keeps strobes one cycle long and never issues both at once.
*/
// Chosen here: the placing of the registers and the strobed register port.
// Functional notes
// - one 10-bit dead-time register for all pairs
// - dead gap is twice the dead-time value
// - values up to 0x3FF, zero means no gap
// - control bit 2 picks double update, reset single
// - one sync per period latches all settings but the update mode bit
// - sync also latches output disable mask
// - double mode adds midpoint sync with latching
// - status bit 0 shows second half
// - three 16-bit duty registers, one per phase
// - outputs active high
// - both edges shifted equally by dead time
// - on times follow period plus twice duty terms
// - on times clamp between zero and full period
// - double mode halves use their own values
// - phases b and c built like phase a
// - outputs held off until four registers written
// - period write starts timer, first sync offset
// - double mode doubles the sync rate
// - period register counts one half period
`timescale 1ns/1ps
`include "tpw_defs.svh"

module tpw_timing_unit
    import tpw_pkg::*;
#(
    parameter int CNT_W = 16,  // period, duty and data width
    parameter int DT_W  = 10   // dead-time width
) (
    input  wire logic                  ref_clk,          // core clock
    input  wire logic                  nrst,             // sync reset
    input  wire logic [`TPW_ADDR_W-1:0] addr,            // byte address
    input  wire logic [CNT_W-1:0]      wr_data,          // write data
    input  wire logic                  wr_en,            // write strobe
    input  wire logic                  rd_en,            // read strobe
    output logic [CNT_W-1:0]           rd_data,          // read data
    output logic                       high_side_a,      // gate a high
    output logic                       low_side_a,       // gate a low
    output logic                       high_side_b,      // gate b high
    output logic                       low_side_b,       // gate b low
    output logic                       high_side_c,      // gate c high
    output logic                       low_side_c,       // gate c low
    output logic                       cycle_sync_pulse  // sync pulse
);

    // software-visible registers
    logic [CNT_W-1:0]       half_period_count_ff;  // half period
    logic [DT_W-1:0]        dead_time_count_ff;    // dead time
    logic [CNT_W-1:0]       duty_ff [3];           // duty a, b, c
    logic [`TPW_MASK_W-1:0] output_enable_mask_ff; // set bit = off
    logic                   mode_double_ff;        // update mode
    logic [3:0]             written_ff;            // period, duties

    // values latched at each sync
    logic [CNT_W-1:0]       per_sh_ff;         // half period
    logic [DT_W-1:0]        dt_sh_ff;          // dead time
    logic [CNT_W-1:0]       duty_sh_ff [3];    // duties
    logic [`TPW_MASK_W-1:0] mask_sh_ff;        // disable mask

    // sequencer and outputs
    tpw_state_t             st_ff;             // half-cycle state
    logic [CNT_W-1:0]       cnt_ff;            // center counter
    logic                   run_ff;            // outputs allowed
    logic                   sync_ff;           // sync pulse flop
    logic [2:0]             hs_ff;             // high-side flops
    logic [2:0]             ls_ff;             // low-side flops
    logic [CNT_W-1:0]       rd_data_ff;        // read data flop
    logic [CNT_W-1:0]       nxt_rd_data;       // read mux

    // decoded events
    logic                   per_wr;            // period write
    logic                   start_evt;         // timer start
    logic                   mid_evt;           // last first-half count
    logic                   end_evt;           // last second-half count
    logic                   sync_evt;          // sync this cycle
    logic                   load_evt;          // shadows load
    logic [CNT_W-1:0]       live_per;          // period incl. write
    logic [2:0]             hi_on;             // compare, high side
    logic [2:0]             lo_on;             // compare, low side

    // duty slot of an address, 3 when none; used by write and read
    function automatic logic [1:0] duty_slot(
        input logic [`TPW_ADDR_W-1:0] a
    );
        logic [1:0] s;
        s = 2'h3;
        if (a == `TPW_A_DUTY_A) begin
            s = 2'h0;
        end else if (a == `TPW_A_DUTY_B) begin
            s = 2'h1;
        end else if (a == `TPW_A_DUTY_C) begin
            s = 2'h2;
        end
        return s;
    endfunction

    assign per_wr    = wr_en && (addr == `TPW_A_PER);
    assign live_per  = per_wr ? wr_data : half_period_count_ff;
    assign start_evt = (st_ff == TPW_IDLE) && per_wr;
    assign mid_evt   = (st_ff == TPW_FIRST)
                       && (cnt_ff >= per_sh_ff - 16'h0001);
    assign end_evt   = (st_ff == TPW_SECOND) && (cnt_ff == '0);
    // midpoint sync only in double mode
    assign sync_evt  = end_evt || (mid_evt && mode_double_ff);
    assign load_evt  = sync_evt || start_evt;

    // register writes; values are live at once, used at next sync, except the mode bit, used at once
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            half_period_count_ff  <= `TPW_RST_WORD;
            dead_time_count_ff    <= `TPW_RST_DT;
            output_enable_mask_ff <= `TPW_RST_MASK;
            mode_double_ff        <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                duty_ff[i] <= `TPW_RST_WORD;
            end
        end else if (wr_en) begin
            // unmapped addresses are ignored
            if (addr == `TPW_A_CTRL) begin
                mode_double_ff <= wr_data[`TPW_CTRL_MODE_BIT];
            end
            if (addr == `TPW_A_PER) begin
                half_period_count_ff <= wr_data;
            end
            if (addr == `TPW_A_DT) begin
                // full 10-bit range, zero allowed
                dead_time_count_ff <= wr_data[DT_W-1:0];
            end
            if (addr == `TPW_A_MASK) begin
                output_enable_mask_ff <= wr_data[`TPW_MASK_W-1:0];
            end
            if (duty_slot(addr) != 2'h3) begin
                duty_ff[duty_slot(addr)] <= wr_data;
            end
        end
    end

    // write-once tracking of period and three duties
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            written_ff <= 4'h0;
            run_ff     <= 1'b0;
        end else begin
            if (per_wr) begin
                written_ff[0] <= 1'b1;
            end
            if (wr_en && (duty_slot(addr) != 2'h3)) begin
                written_ff[duty_slot(addr) + 2'h1] <= 1'b1;
            end
            // counters run meanwhile, outputs wait for all four
            run_ff <= &written_ff;
        end
    end

    // shadow latch at start and at every sync edge
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            per_sh_ff  <= `TPW_RST_WORD;
            dt_sh_ff   <= `TPW_RST_DT;
            mask_sh_ff <= `TPW_RST_MASK;
            for (int i = 0; i < 3; i++) begin
                duty_sh_ff[i] <= `TPW_RST_WORD;
            end
        end else if (load_evt) begin
            // a period write in the same cycle is taken along
            per_sh_ff  <= live_per;
            dt_sh_ff   <= dead_time_count_ff;
            mask_sh_ff <= output_enable_mask_ff;
            for (int i = 0; i < 3; i++) begin
                duty_sh_ff[i] <= duty_ff[i];
            end
        end
    end

    // center counter: up in first half, down in second half
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_ff  <= TPW_IDLE;
            cnt_ff <= '0;
        end else begin
            unique case (st_ff)
                TPW_IDLE: begin
                    if (per_wr) begin
                        st_ff <= TPW_FIRST;
                        // single starts mid first half: first sync at
                        // 1.5 periods; double at 0 so midpoint comes
                        // after one period value
                        cnt_ff <= mode_double_ff ? '0 : (wr_data >> 1);
                    end
                end
                TPW_FIRST: begin
                    if (mid_evt) begin
                        st_ff <= TPW_SECOND;
                        // double mode second half takes new period
                        cnt_ff <= (mode_double_ff ? live_per : per_sh_ff)
                                  - 16'h0001;
                    end else begin
                        cnt_ff <= cnt_ff + 16'h0001;
                    end
                end
                TPW_SECOND: begin
                    if (end_evt) begin
                        st_ff  <= TPW_FIRST;
                        cnt_ff <= '0;
                    end else begin
                        cnt_ff <= cnt_ff - 16'h0001;
                    end
                end
                default: begin
                    // illegal one-hot code recovers to idle
                    st_ff  <= TPW_IDLE;
                    cnt_ff <= '0;
                end
            endcase
        end
    end

    // one-cycle sync pulse, rises with the new half
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sync_ff <= 1'b0;
        end else begin
            sync_ff <= sync_evt;
        end
    end

    // identical compare for every phase
    for (genvar g = 0; g < 3; g++) begin : g_phase
        tpw_phase_cmp #(
            .CNT_W (CNT_W),
            .DT_W  (DT_W)
        ) u_cmp (
            .cnt   (cnt_ff),
            .per   (per_sh_ff),
            .duty  (duty_sh_ff[g]),
            .dt    (dt_sh_ff),
            .hi_on (hi_on[g]),
            .lo_on (lo_on[g])
        );
    end

    // gate flops; mask bit 5-2i kills high i, 4-2i kills low i
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            hs_ff <= 3'h0;
            ls_ff <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                // high level means switch on
                hs_ff[i] <= run_ff && (st_ff != TPW_IDLE) && hi_on[i]
                            && !mask_sh_ff[5 - 2*i];
                ls_ff[i] <= run_ff && (st_ff != TPW_IDLE) && lo_on[i]
                            && !mask_sh_ff[4 - 2*i];
            end
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        nxt_rd_data = '0;
        if (addr == `TPW_A_CTRL) begin
            nxt_rd_data[`TPW_CTRL_MODE_BIT] = mode_double_ff;
        end
        if (addr == `TPW_A_STAT) begin
            nxt_rd_data[`TPW_STAT_HALF_BIT] = (st_ff == TPW_SECOND);
        end
        if (addr == `TPW_A_PER) begin
            nxt_rd_data = half_period_count_ff;
        end
        if (addr == `TPW_A_DT) begin
            nxt_rd_data[DT_W-1:0] = dead_time_count_ff;
        end
        if (addr == `TPW_A_MASK) begin
            nxt_rd_data[`TPW_MASK_W-1:0] = output_enable_mask_ff;
        end
        if (duty_slot(addr) != 2'h3) begin
            nxt_rd_data = duty_ff[duty_slot(addr)];
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rd_data_ff <= '0;
        end else begin
            rd_data_ff <= rd_en ? nxt_rd_data : '0;
        end
    end

    assign rd_data          = rd_data_ff;
    assign high_side_a      = hs_ff[0];
    assign low_side_a       = ls_ff[0];
    assign high_side_b      = hs_ff[1];
    assign low_side_b       = ls_ff[1];
    assign high_side_c      = hs_ff[2];
    assign low_side_c       = ls_ff[2];
    assign cycle_sync_pulse = sync_ff;

    // checks on the design's own behaviour
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    AST_SYNC_ONE_CYCLE: assert property (
        sync_ff |=> !sync_ff
    ) else $error("sync pulse longer than one cycle");

    AST_MODE_AFTER_RESET: assert property (
        @(posedge ref_clk) disable iff (1'b0)
        !nrst |=> !mode_double_ff
    ) else $error("update mode not single after reset");

    AST_MASK_AT_SYNC: assert property (
        sync_ff |-> mask_sh_ff == $past(output_enable_mask_ff)
    ) else $error("disable mask not latched at sync");

    AST_DT_AT_SYNC: assert property (
        sync_ff |-> dt_sh_ff == $past(dead_time_count_ff)
    ) else $error("dead time not latched at sync");

    AST_MID_SYNC_DOUBLE: assert property (
        $past(mode_double_ff) && $rose(st_ff == TPW_SECOND) |-> sync_ff
    ) else $error("no midpoint sync in double mode");

    AST_NO_MID_SYNC_SINGLE: assert property (
        !$past(mode_double_ff) && $rose(st_ff == TPW_SECOND) |-> !sync_ff
    ) else $error("midpoint sync in single mode");

    AST_PAIR_NO_OVERLAP: assert property (
        !(hs_ff[0] && ls_ff[0]) && !(hs_ff[1] && ls_ff[1])
        && !(hs_ff[2] && ls_ff[2])
    ) else $error("both switches of a pair on");

    AST_OFF_BEFORE_RUN: assert property (
        !run_ff |=> (hs_ff == 3'h0) && (ls_ff == 3'h0)
    ) else $error("output before all registers written");

    AST_PERIOD_WRAP: assert property (
        end_evt |=> (st_ff == TPW_FIRST) && (cnt_ff == '0) && sync_ff
    ) else $error("period end did not restart the count");

    AST_DT_READBACK: assert property (
        rd_en && (addr == `TPW_A_DT) && !wr_en
        |=> rd_data_ff == CNT_W'($past(dead_time_count_ff))
    ) else $error("dead time readback mismatch");

    COV_DOUBLE_SYNC: cover property (
        mode_double_ff && sync_ff && (st_ff == TPW_SECOND)
    );
    COV_HIGH_ON: cover property (run_ff && hs_ff[0]);
    COV_LOW_ON: cover property (run_ff && ls_ff[2]);

endmodule

// file: tb/tpw_gate_drv_model.sv
/*
 tpw_gate_drv_model: behavioural gate-driver side of the pwm timing unit.
 counts on cycles of each gate between sync pulses and flags shoot-through.
 assumes: same core clock as the unit, sync pulse one cycle wide.
*/
`timescale 1ns/1ps

module tpw_gate_drv_model
    import tpw_pkg::*;
(
    input  wire logic             ref_clk,   // core clock
    input  wire logic             nrst,      // sync reset, active low
    input  wire logic             sync_in,   // cycle sync pulse
    input  wire logic [5:0]       gates,     // a-hi a-lo b-hi b-lo c-hi c-lo
    output logic      [5:0][15:0] on_cnt_ff, // on cycles, last window
    output logic      [5:0][15:0] on_two_ff, // on cycles, last two windows
    output logic      [15:0]      gap_ff,    // cycles between last syncs
    output logic                  shoot_ff   // sticky: both of a pair on
);
    logic [5:0][15:0] acc_ff;  // running on counts
    logic [15:0]      gcnt_ff; // running window length

    // window counters; a high level means the switch conducts
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            acc_ff    <= '0;
            on_cnt_ff <= '0;
            on_two_ff <= '0;
            gap_ff    <= 16'h0000;
            gcnt_ff   <= 16'h0000;
        end else if (sync_in) begin
            // close window; two-window sum hides where a pulse is split
            for (int i = 0; i < 6; i++) begin
                on_cnt_ff[i] <= acc_ff[i];
                on_two_ff[i] <= acc_ff[i] + on_cnt_ff[i];
                acc_ff[i]    <= {15'h0000, gates[i]};
            end
            gap_ff  <= gcnt_ff;
            gcnt_ff <= 16'h0001;
        end else begin
            for (int i = 0; i < 6; i++) begin
                acc_ff[i] <= acc_ff[i] + {15'h0000, gates[i]};
            end
            gcnt_ff <= gcnt_ff + 16'h0001;
        end
    end

    // a real bridge leg would short the dc link here
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            shoot_ff <= 1'b0;
        end else if ((gates[5] & gates[4]) | (gates[3] & gates[2]) | (gates[1] & gates[0])) begin
            shoot_ff <= 1'b1;
        end
    end
endmodule

// file: tb/tb.sv
/*
 tb: self-checking bench of the three-phase pwm timing unit.
 assumes: register offsets from tpw_defs.svh, gate-driver model beside.
*/
`timescale 1ns/1ps
`include "tpw_defs.svh"

module tb
    import tpw_pkg::*;
;
    localparam int P = 20;           // half period in core clocks
    logic              ref_clk;      // core clock
    logic              nrst;         // sync reset
    logic [4:0]        addr;         // register address
    logic [15:0]       wr_data;      // write data
    logic              wr_en;        // write strobe
    logic              rd_en;        // read strobe
    logic [15:0]       rd_data;      // read data
    logic [5:0]        gates;        // gate commands, mask order
    logic              sync;         // cycle sync pulse
    logic [5:0][15:0]  on_cnt;       // model: last window
    logic [5:0][15:0]  on_two;       // model: two windows
    logic [15:0]       gap;          // model: sync spacing
    logic              shoot;        // model: overlap seen
    int                mismatches;   // failed compares
    int                checked;      // all compares
    int                n;            // cycle counter
    int                dty[3];       // duty per phase

    tpw_timing_unit #(.CNT_W(16), .DT_W(10)) tpw_timing_unit_i (
        .ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .high_side_a(gates[5]), .low_side_a(gates[4]), .high_side_b(gates[3]),
        .low_side_b(gates[2]), .high_side_c(gates[1]), .low_side_c(gates[0]),
        .cycle_sync_pulse(sync));

    tpw_gate_drv_model tpw_gate_drv_model_i (
        .ref_clk(ref_clk), .nrst(nrst), .sync_in(sync), .gates(gates),
        .on_cnt_ff(on_cnt), .on_two_ff(on_two), .gap_ff(gap), .shoot_ff(shoot));

    // free-running core clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one-cycle write strobe, held until the taking edge
    task automatic wr(logic [4:0] a, logic [15:0] d);
        @(posedge ref_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask

    // read, data valid the cycle after the strobe only
    task automatic rd_chk(string what, logic [4:0] a, logic [15:0] exp);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 check(what, exp, rd_data);
        @(posedge ref_clk);
        #1 check({what, " idle"}, 16'h0000, rd_data);
    endtask

    // bounded wait for n sync pulses
    task automatic wait_sync(int cnt);
        int k;
        repeat (cnt) begin
            k = 0;
            @(posedge ref_clk);
            while (sync !== 1'b1 && k < 200) begin
                @(posedge ref_clk);
                k++;
            end
            if (k >= 200) check("sync wait", 16'h0001, 16'h0000);
        end
        #1;
    endtask

    // on cycles per full period, clamped to 0..2P
    function automatic logic [15:0] on_exp(int d, int t, bit hi);
        int v;
        v = hi ? P + 2 * (d - t) : P - 2 * (d + t);
        if (v < 0) v = 0;
        if (v > 2 * P) v = 2 * P;
        return v[15:0];
    endfunction

    // main sequence
    initial begin
        addr = 5'h00; wr_data = 16'h0000; wr_en = 1'b0; rd_en = 1'b0;
        mismatches = 0; checked = 0; dty = '{3, -3, 0};
        nrst = 1'b0;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        // reset values and an unmapped hole read as zero
        rd_chk("ctrl", `TPW_A_CTRL, 16'h0000);
        rd_chk("dead", `TPW_A_DT, 16'h0000);
        rd_chk("duty", `TPW_A_DUTY_C, 16'h0000);
        rd_chk("hole", 5'h02, 16'h0000);
        wr(`TPW_A_DT, 16'hffff);
        rd_chk("dead max", `TPW_A_DT, 16'h03ff);
        wr(`TPW_A_DUTY_A, 16'habcd);
        rd_chk("duty a", `TPW_A_DUTY_A, 16'habcd);
        $display("test registers done");
        // period starts the timer; b and c duties still unwritten
        wr(`TPW_A_PER, 16'h0014);
        n = 0;
        // sample a settled sync, away from the edge that launches it
        while (sync !== 1'b1 && n < 100) begin
            @(posedge ref_clk);
            #1;
            n++;
            if (gates !== 6'h00) check("gates off", 16'h0000, {10'h000, gates});
        end
        check("first sync", 16'h0001, {15'h0000, n >= 30 && n <= 33});
        $display("test start done");
        // steady single-mode pattern, three phases
        wr(`TPW_A_DUTY_B, 16'hfffd);
        wr(`TPW_A_DUTY_C, 16'h0000);
        wr(`TPW_A_DUTY_A, 16'h0003);
        wr(`TPW_A_DT, 16'h0002);
        wait_sync(3);
        check("period gap", 16'h0028, gap);
        for (int i = 0; i < 3; i++) begin
            check("hi on", on_exp(dty[i], 2, 1'b1), on_cnt[5 - 2 * i]);
            check("lo on", on_exp(dty[i], 2, 1'b0), on_cnt[4 - 2 * i]);
        end
        $display("test single done");
        // half status: clear first half, set second half
        wait_sync(1);
        repeat (5) @(posedge ref_clk);
        rd_chk("half 1", `TPW_A_STAT, 16'h0000);
        repeat (P) @(posedge ref_clk);
        rd_chk("half 2", `TPW_A_STAT, 16'h0001);
        $display("test status done");
        // mask takes effect at a sync boundary
        wr(`TPW_A_MASK, 16'h0020);
        wait_sync(2);
        check("masked hi", 16'h0000, on_cnt[5]);
        check("unmasked lo", on_exp(3, 2, 1'b0), on_cnt[4]);
        wr(`TPW_A_MASK, 16'h0000);
        $display("test mask done");
        // zero dead time and clamping at full period
        wr(`TPW_A_DT, 16'h0000);
        wr(`TPW_A_DUTY_A, 16'h000f);
        wr(`TPW_A_DUTY_B, 16'h0000);
        wait_sync(3);
        check("clamp hi", on_exp(15, 0, 1'b1), on_cnt[5]);
        check("clamp lo", 16'h0000, on_cnt[4]);
        check("zero dt hi", 16'h0014, on_cnt[3]);
        check("zero dt lo", 16'h0014, on_cnt[2]);
        $display("test clamp done");
        // double update: sync every half, two halves make a period
        wr(`TPW_A_DT, 16'h0002);
        wr(`TPW_A_DUTY_A, 16'h0003);
        wr(`TPW_A_CTRL, 16'h0004);
        rd_chk("ctrl", `TPW_A_CTRL, 16'h0004);
        wait_sync(5);
        check("half gap", 16'h0014, gap);
        check("dbl hi", on_exp(3, 2, 1'b1), on_two[5]);
        check("dbl lo", on_exp(3, 2, 1'b0), on_two[4]);
        check("overlap", 16'h0000, {15'h0000, shoot});
        $display("test double done");
        // second reset, then a double-mode start: first sync after one P
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        wr(`TPW_A_CTRL, 16'h0004);
        rd_chk("ctrl again", `TPW_A_CTRL, 16'h0004);
        wr(`TPW_A_PER, 16'h0014);
        n = 0;
        while (sync !== 1'b1 && n < 100) begin
            @(posedge ref_clk);
            #1;
            n++;
            if (gates !== 6'h00) check("gates off 2", 16'h0000, {10'h000, gates});
        end
        check("dbl first sync", 16'h0014, n[15:0]);
        $display("test restart done");
        final_report();
    end

    // watchdog: the sequence needs well under 3000 cycles
    initial begin
        #80000;
        mismatches++;
        final_report();
    end
endmodule
